// ==== verilog/cbeq_pkg.sv ====
// Purpose: constants and carrier types for the channel B equalizer
// Assumes: register indexes times four give the APB byte address
// Notes:   all coefficient fields reset to zero
package cbeq_pkg;

    ////////////////////////////////////////////////////////////////////////
    // filter shape
    localparam int NTAPS       = 9;
    localparam int SAMP_W      = 12;
    localparam int COEF_W      = 12;
    localparam int CTR_COEF_W  = 18;
    localparam int CTR_TAP     = 4;
    localparam int PROD_W      = SAMP_W + CTR_COEF_W;
    localparam int ACC_W       = PROD_W + 4;
    localparam int FIFO_DEPTH  = 4;

    ////////////////////////////////////////////////////////////////////////
    // register widths and reset values
    localparam int          REG_W      = 16;
    localparam int          CTR_REG_W  = 24;
    localparam int          RAW_W      = 24;
    localparam logic [23:0] COEF_RST   = 24'h000000;
    localparam logic        CTRL_RST   = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // register indexes (byte address = 4 * index)
    localparam int          IDX_W      = 11;
    localparam logic [10:0] IDX_TAP1   = 11'h448;
    localparam logic [10:0] IDX_TAP2   = 11'h44a;
    localparam logic [10:0] IDX_TAP3   = 11'h44c;
    localparam logic [10:0] IDX_TAP4   = 11'h44e;
    localparam logic [10:0] IDX_CENTER = 11'h450;
    localparam logic [10:0] IDX_TAP6   = 11'h453;
    localparam logic [10:0] IDX_TAP7   = 11'h455;
    localparam logic [10:0] IDX_TAP8   = 11'h457;
    localparam logic [10:0] IDX_TAP9   = 11'h459;
    localparam logic [10:0] IDX_CTRL   = 11'h460;
    localparam logic [10:0] IDX_STATUS = 11'h461;

    ////////////////////////////////////////////////////////////////////////
    // control and status fields
    localparam int CTRL_DUAL_BIT  = 0;
    localparam int ST_LEVEL_LSB   = 0;
    localparam int ST_LEVEL_W     = 8;
    localparam int ST_DUAL_BIT    = 8;
    localparam int ST_OUTV_BIT    = 9;

    ////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic              valid;
        logic [SAMP_W-1:0] data;
    } cbeq_samp_t;

    typedef struct packed {
        logic             valid;
        logic [ACC_W-1:0] data;
    } cbeq_res_t;

    typedef struct packed {
        logic [NTAPS-1:0][RAW_W-1:0]  coef;
        logic [NTAPS-1:0][SAMP_W-1:0] hist;
        logic                         dual;
        logic [ACC_W-1:0]             y;
        logic                         y_vld;
        logic [31:0]                  rdata;
        logic                         slverr;
    } cbeq_state_t;

endpackage

// ==== verilog/cbeq_top.sv ====
// Purpose: channel B nine-tap equalizer with APB coefficient registers
// Assumes: samples arrive on pclk; APB slave answers with zero wait states
// Notes:   input FIFO of four samples sits ahead of the tap line
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// sample fifo
module cbeq_fifo #(
    parameter int W = 12,
    parameter int D = 4
) (
    input  wire logic           clk,
    input  wire logic           rst_n,
    input  wire logic           in_valid,
    input  wire logic [W-1:0]   in_data,
    output logic                in_ready,
    output logic                out_valid,
    output logic      [W-1:0]   out_data,
    input  wire logic           out_ready,
    output logic      [7:0]     level
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    localparam int CW = $clog2(D + 1);
    localparam logic [AW-1:0] LAST = AW'(D - 1);
    localparam logic [CW-1:0] FULL = CW'(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [CW-1:0]       cnt;
    } cbeq_fifo_st_t;

    cbeq_fifo_st_t st_r;
    cbeq_fifo_st_t st_nxt;
    logic          push;
    logic          pop;

    assign in_ready  = (st_r.cnt != FULL);
    assign out_valid = (st_r.cnt != '0);
    assign out_data  = st_r.mem[st_r.rp];
    assign level     = 8'(st_r.cnt);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.mem[st_r.wp] = in_data;
            st_nxt.wp = (st_r.wp == LAST) ? '0 : st_r.wp + 1'b1;
        end
        if (pop) begin
            st_nxt.rp = (st_r.rp == LAST) ? '0 : st_r.rp + 1'b1;
        end
        if (push && !pop) begin
            st_nxt.cnt = st_r.cnt + 1'b1;
        end else if (pop && !push) begin
            st_nxt.cnt = st_r.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////
// equalizer top
module cbeq_top #(
    parameter int ADDR_W     = 16,
    parameter int FIFO_DEPTH = cbeq_pkg::FIFO_DEPTH
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [ADDR_W-1:0]    paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire cbeq_pkg::cbeq_samp_t smp_in,
    output logic                      smp_ready,
    output cbeq_pkg::cbeq_res_t       res_out,
    input  wire logic                 res_ready
);
    localparam logic [3:0] NO_TAP = 4'hf;

    cbeq_pkg::cbeq_state_t st_r;
    cbeq_pkg::cbeq_state_t st_nxt;

    logic                        f_vld;
    logic [cbeq_pkg::SAMP_W-1:0] f_data;
    logic                        f_rdy;
    logic [7:0]                  f_level;

    ////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [3:0] tap_of(input logic [ADDR_W-1:0] a);
        logic [cbeq_pkg::IDX_W-1:0] idx;
        logic                       ok;
        idx = a[cbeq_pkg::IDX_W+1:2];
        ok  = (a[1:0] == 2'h0) && ((a >> (cbeq_pkg::IDX_W + 2)) == '0);
        tap_of = NO_TAP;
        if (ok) begin
            case (idx)
                cbeq_pkg::IDX_TAP1:   tap_of = 4'h0;
                cbeq_pkg::IDX_TAP2:   tap_of = 4'h1;
                cbeq_pkg::IDX_TAP3:   tap_of = 4'h2;
                cbeq_pkg::IDX_TAP4:   tap_of = 4'h3;
                cbeq_pkg::IDX_CENTER: tap_of = 4'h4;
                cbeq_pkg::IDX_TAP6:   tap_of = 4'h5;
                cbeq_pkg::IDX_TAP7:   tap_of = 4'h6;
                cbeq_pkg::IDX_TAP8:   tap_of = 4'h7;
                cbeq_pkg::IDX_TAP9:   tap_of = 4'h8;
                default:              tap_of = NO_TAP;
            endcase
        end
    endfunction

    function automatic logic [cbeq_pkg::IDX_W-1:0] idx_of(
        input logic [ADDR_W-1:0] a
    );
        idx_of = a[cbeq_pkg::IDX_W+1:2];
    endfunction

    function automatic logic aligned(input logic [ADDR_W-1:0] a);
        aligned = (a[1:0] == 2'h0) && ((a >> (cbeq_pkg::IDX_W + 2)) == '0);
    endfunction

    // signed coefficient of one tap, widened to the center width
    function automatic logic signed [cbeq_pkg::CTR_COEF_W-1:0] coef_val(
        input int                              t,
        input logic [cbeq_pkg::RAW_W-1:0]      raw
    );
        if (t == cbeq_pkg::CTR_TAP) begin
            coef_val = $signed(raw[cbeq_pkg::CTR_COEF_W-1:0]);
        end else begin
            coef_val = cbeq_pkg::CTR_COEF_W'($signed(
                raw[cbeq_pkg::COEF_W-1:0]));
        end
    endfunction

    // newest sample meets the first tap
    function automatic logic [cbeq_pkg::ACC_W-1:0] dot(
        input logic [cbeq_pkg::NTAPS-1:0][cbeq_pkg::SAMP_W-1:0] h,
        input logic [cbeq_pkg::NTAPS-1:0][cbeq_pkg::RAW_W-1:0]  c
    );
        logic signed [cbeq_pkg::ACC_W-1:0]  acc;
        logic signed [cbeq_pkg::PROD_W-1:0] p;
        acc = '0;
        for (int i = 0; i < cbeq_pkg::NTAPS; i++) begin
            p   = $signed(h[i]) * coef_val(i, c[i]);
            acc = acc + cbeq_pkg::ACC_W'(p);
        end
        dot = acc;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // input buffer
    cbeq_fifo #(
        .W (cbeq_pkg::SAMP_W),
        .D (FIFO_DEPTH)
    ) u_fifo (
        .clk       (pclk),
        .rst_n     (presetn),
        .in_valid  (smp_in.valid),
        .in_data   (smp_in.data),
        .in_ready  (smp_ready),
        .out_valid (f_vld),
        .out_data  (f_data),
        .out_ready (f_rdy),
        .level     (f_level)
    );

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign pready        = 1'b1;
    assign prdata        = st_r.rdata;
    assign pslverr       = st_r.slverr && psel && penable;
    assign res_out.valid = st_r.y_vld;
    assign res_out.data  = st_r.y;
    assign f_rdy         = !st_r.y_vld || res_ready;

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        logic [3:0]                                       t;
        logic [cbeq_pkg::NTAPS-1:0][cbeq_pkg::SAMP_W-1:0] h;
        logic [ADDR_W-1:0]                                a;
        st_nxt = st_r;
        a      = paddr;
        t      = tap_of(a);
        h      = st_r.hist;

        // setup phase: latch read data and error for the access phase
        if (psel && !penable) begin
            st_nxt.rdata  = 32'h0;
            st_nxt.slverr = 1'b0;
            if (t != NO_TAP) begin
                st_nxt.rdata = 32'(st_r.coef[t]);
            end else if (aligned(a) && idx_of(a) == cbeq_pkg::IDX_CTRL) begin
                st_nxt.rdata[cbeq_pkg::CTRL_DUAL_BIT] = st_r.dual;
            end else if (aligned(a) && idx_of(a) == cbeq_pkg::IDX_STATUS) begin
                st_nxt.rdata[cbeq_pkg::ST_LEVEL_LSB +: cbeq_pkg::ST_LEVEL_W] =
                    f_level;
                st_nxt.rdata[cbeq_pkg::ST_DUAL_BIT] = st_r.dual;
                st_nxt.rdata[cbeq_pkg::ST_OUTV_BIT] = st_r.y_vld;
            end else begin
                st_nxt.slverr = 1'b1;
            end
            if (pwrite && aligned(a) && idx_of(a) == cbeq_pkg::IDX_STATUS) begin
                st_nxt.slverr = 1'b1;
            end
        end

        // access phase: writes land here
        if (psel && penable && pwrite) begin
            if (t == 4'(cbeq_pkg::CTR_TAP)) begin
                st_nxt.coef[t] = pwdata[cbeq_pkg::CTR_REG_W-1:0];
            end else if (t != NO_TAP) begin
                st_nxt.coef[t] = {8'h00, pwdata[cbeq_pkg::REG_W-1:0]};
            end else if (aligned(a) && idx_of(a) == cbeq_pkg::IDX_CTRL) begin
                st_nxt.dual = pwdata[cbeq_pkg::CTRL_DUAL_BIT];
            end
        end

        // tap line and result register
        if (f_vld && f_rdy) begin
            for (int i = cbeq_pkg::NTAPS - 1; i > 0; i--) begin
                h[i] = st_r.hist[i-1];
            end
            h[0]         = f_data;
            st_nxt.hist  = h;
            st_nxt.y_vld = 1'b1;
            if (st_r.dual) begin
                st_nxt.y = dot(h, st_r.coef);
            end else begin
                st_nxt.y = cbeq_pkg::ACC_W'($signed(f_data));
            end
        end else if (res_ready) begin
            st_nxt.y_vld = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r        <= '0;
            st_r.coef   <= {cbeq_pkg::NTAPS{cbeq_pkg::COEF_RST}};
            st_r.dual   <= cbeq_pkg::CTRL_RST;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule

`default_nettype wire

// ==== verif/cbeq_chk.sv ====
// Purpose: protocol and register checks on the equalizer top
// Assumes: zero-wait APB slave
// Notes:   sees top ports only
`timescale 1ns/100ps
`default_nettype none
module cbeq_chk #(
    parameter int ADDR_W     = 16,
    parameter int FIFO_DEPTH = 4
) (
    input wire logic                pclk,
    input wire logic                presetn,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [ADDR_W-1:0]   paddr,
    input wire logic [31:0]         pwdata,
    input wire logic [31:0]         prdata,
    input wire logic                pready,
    input wire logic                pslverr,
    input wire cbeq_pkg::cbeq_samp_t smp_in,
    input wire logic                smp_ready,
    input wire cbeq_pkg::cbeq_res_t res_out,
    input wire logic                res_ready
);
    localparam logic [15:0] A1 = {3'h0, cbeq_pkg::IDX_TAP1, 2'h0};
    localparam logic [15:0] A2 = {3'h0, cbeq_pkg::IDX_TAP2, 2'h0};
    localparam logic [15:0] AC = {3'h0, cbeq_pkg::IDX_CENTER, 2'h0};
    localparam logic [15:0] A6 = {3'h0, cbeq_pkg::IDX_TAP6, 2'h0};
    wire         acc = psel && penable;
    wire         rd  = acc && !pwrite;
    logic [15:0] t6_r;
    logic [23:0] ct_r;
    ////////////////////
    // last written tap6 and center words
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t6_r <= 16'h0;
            ct_r <= 24'h0;
        end else if (acc && pwrite && paddr == A6) begin
            t6_r <= pwdata[15:0];
        end else if (acc && pwrite && paddr == AC) begin
            ct_r <= pwdata[23:0];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_err_zero: assert property (rd && pslverr |-> prdata == 32'h0)
        else $error("refused read returned data");
    a_misalign_err: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned access not refused");
    a_tap1_mapped: assert property (acc && paddr == A1 |-> !pslverr && pready)
        else $error("tap1 access refused");
    a_outer_rsvd: assert property (rd && paddr == A2 |-> prdata[31:16] == 16'h0)
        else $error("tap2 upper bits not zero");
    a_center_rsvd: assert property (rd && paddr == AC |-> prdata[31:24] == 8'h0)
        else $error("center upper bits not zero");
    a_tap6_back: assert property (rd && paddr == A6 |-> prdata[15:0] == t6_r)
        else $error("tap6 readback wrong");
    a_center_back: assert property (rd && paddr == AC |-> prdata[23:0] == ct_r)
        else $error("center readback wrong");
    a_res_hold: assert property (res_out.valid && !res_ready |=>
        res_out.valid && $stable(res_out.data)) else $error("result dropped");
    a_ready_wakes: assert property ($rose(presetn) |-> smp_ready && !res_out.valid)
        else $error("stream not idle after reset");
    c_write: cover property (acc && pwrite);
    c_result: cover property (res_out.valid && res_ready);
    c_full: cover property (!smp_ready);
endmodule
`default_nettype wire

// ==== verif/cbeq_stream_model.sv ====
// Purpose: sample source and result sink at the far side
// Assumes: driven after rising clk
// Notes:   stall holds off result acceptance
`timescale 1ns/100ps
`default_nettype none
module cbeq_stream_model (
    input wire logic                 clk,
    input wire logic                 rst_n,
    input wire logic                 stall,
    input wire logic                 smp_ready,
    input wire cbeq_pkg::cbeq_res_t  res_out,
    output var cbeq_pkg::cbeq_samp_t smp_in,
    output var logic                 res_ready
);
    logic [11:0] tx_q[$];
    logic [33:0] rx_q[$];
    int          sent = 0;
    initial begin
        smp_in = '0;
        res_ready = 1'b0;
    end
    // idle data toggles so a stale sample cannot pass
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            smp_in.valid <= 1'b0;
            res_ready <= 1'b0;
        end else begin
            if (smp_in.valid && smp_ready) begin
                void'(tx_q.pop_front());
                sent++;
            end
            smp_in.valid <= tx_q.size() > 0;
            smp_in.data <= tx_q.size() > 0 ? tx_q[0] : ~smp_in.data;
            if (res_out.valid && res_ready) rx_q.push_back(res_out.data);
            res_ready <= !stall;
        end
    end
endmodule
`default_nettype wire

// ==== verif/cbeq_top_tb_top.sv ====
// Purpose: self-checking bench for the equalizer
// Assumes: zero-wait APB, stream model at far side
// Notes:   filter scenario runs before bypass so history starts clear
`timescale 1ns/100ps
`default_nettype none
module cbeq_top_tb_top;
    localparam int ADDR_W = 16;
    localparam int FIFO_DEPTH = 4;
    localparam logic [10:0] TAP_IDX[9] = '{cbeq_pkg::IDX_TAP1, cbeq_pkg::IDX_TAP2,
        cbeq_pkg::IDX_TAP3, cbeq_pkg::IDX_TAP4, cbeq_pkg::IDX_CENTER, cbeq_pkg::IDX_TAP6,
        cbeq_pkg::IDX_TAP7, cbeq_pkg::IDX_TAP8, cbeq_pkg::IDX_TAP9};
    localparam int CF[9] = '{1, -1, -2048, 2047, -131072, 291, -292, 5, -256};
    logic                 pclk = 1'b0;
    logic                 presetn = 1'b0;
    logic                 psel = 1'b0;
    logic                 penable = 1'b0;
    logic                 pwrite = 1'b0;
    logic [15:0]          paddr = 16'h0;
    logic [31:0]          pwdata = 32'h0;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    logic                 smp_ready;
    logic                 res_ready;
    logic                 stall = 1'b0;
    int                   num_errors = 0;
    int                   num_checks = 0;
    int                   cyc = 0;
    cbeq_pkg::cbeq_samp_t smp_in;
    cbeq_pkg::cbeq_res_t  res_out;
    cbeq_top #(.ADDR_W(ADDR_W), .FIFO_DEPTH(FIFO_DEPTH)) cbeq_top_i (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .smp_in(smp_in), .smp_ready(smp_ready), .res_out(res_out), .res_ready(res_ready));
    cbeq_stream_model cbeq_stream_model_i (.clk(pclk), .rst_n(presetn), .stall(stall),
        .smp_ready(smp_ready), .res_out(res_out), .smp_in(smp_in), .res_ready(res_ready));
    always #5 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            final_report();
        end
    end
    ////////////////////
    task automatic final_report();
        if (num_errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic chk_res(input logic [33:0] g, input logic [33:0] e);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    function automatic logic [15:0] ba(input logic [10:0] i);
        return {3'h0, i, 2'h0};
    endfunction
    function automatic logic [31:0] pat(input int i);
        return 32'hffff9c31 + 32'(i) * 32'h00001234;
    endfunction
    function automatic logic [11:0] xb(input int i);
        return 12'h800 + 12'(i * 675);
    endfunction
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
        chk_reg({31'h0, e}, 32'h0);
    endtask
    task automatic rdc(input logic [15:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk_reg(r, x);
        chk_reg({31'h0, e}, {31'h0, xe});
    endtask
    ////////////////////
    task automatic t_reset();
        for (int i = 0; i < 9; i++) rdc(ba(TAP_IDX[i]), 32'h0, 1'b0);
        rdc(ba(cbeq_pkg::IDX_CTRL), 32'h0, 1'b0);
    endtask
    task automatic t_regs();
        logic [31:0] m;
        logic [31:0] r;
        logic        e;
        for (int i = 0; i < 9; i++) wr(ba(TAP_IDX[i]), pat(i));
        for (int i = 0; i < 9; i++) begin
            m = (i == 4) ? 32'h00ffffff : 32'h0000ffff;
            rdc(ba(TAP_IDX[i]), pat(i) & m, 1'b0);
        end
        rdc(ba(TAP_IDX[1]) + 16'h1, 32'h0, 1'b1);
        rdc(ba(11'h449), 32'h0, 1'b1);
        // status is read-only: a write is refused
        apb(1'b1, ba(cbeq_pkg::IDX_STATUS), 32'h0, r, e);
        chk_reg({31'h0, e}, 32'h1);
    endtask
    task automatic t_filter();
        int          xs[18] = '{default: 0};
        longint      acc;
        logic [31:0] w;
        for (int k = 0; k < 9; k++) begin
            w = (k == 4) ? (32'h00fc0000 | (CF[k] & 32'h0003ffff))
                         : (32'h0000a000 | (CF[k] & 32'h00000fff));
            wr(ba(TAP_IDX[k]), w);
        end
        wr(ba(cbeq_pkg::IDX_CTRL), 32'h1);
        xs[0] = 2047;
        xs[9] = -2048;
        cbeq_stream_model_i.rx_q.delete();
        for (int n = 0; n < 18; n++) cbeq_stream_model_i.tx_q.push_back(xs[n][11:0]);
        while (cbeq_stream_model_i.rx_q.size() < 18) @(posedge pclk);
        for (int n = 0; n < 18; n++) begin
            acc = 0;
            for (int k = 0; k <= n && k < 9; k++) acc += longint'(xs[n-k]) * CF[k];
            chk_res(cbeq_stream_model_i.rx_q[n], acc[33:0]);
        end
    endtask
    task automatic t_bypass();
        int          s0;
        logic [11:0] x;
        wr(ba(cbeq_pkg::IDX_CTRL), 32'h0);
        cbeq_stream_model_i.rx_q.delete();
        s0 = cbeq_stream_model_i.sent;
        stall <= 1'b1;
        for (int i = 0; i < 8; i++) cbeq_stream_model_i.tx_q.push_back(xb(i));
        do @(posedge pclk); while (smp_ready !== 1'b0);
        chk_reg(32'(cbeq_stream_model_i.sent - s0), 32'(FIFO_DEPTH + 1));
        // stalled: fifo full, result held, single-channel mode
        rdc(ba(cbeq_pkg::IDX_STATUS), (32'h1 << cbeq_pkg::ST_OUTV_BIT) | 32'(FIFO_DEPTH),
            1'b0);
        stall <= 1'b0;
        while (cbeq_stream_model_i.rx_q.size() < 8) @(posedge pclk);
        for (int i = 0; i < 8; i++) begin
            x = xb(i);
            chk_res(cbeq_stream_model_i.rx_q[i], {{22{x[11]}}, x});
        end
    endtask
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_regs();
        t_filter();
        t_bypass();
        final_report();
    end
endmodule
bind cbeq_top cbeq_chk #(.ADDR_W(ADDR_W), .FIFO_DEPTH(FIFO_DEPTH)) cbeq_chk_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .smp_in(smp_in),
    .smp_ready(smp_ready), .res_out(res_out), .res_ready(res_ready));
`default_nettype wire
